// [tpw_pkg.sv]
/*
 * constants for the timer based pulse width unit: register offsets,
 * field positions and values after reset.
 * assumes a byte addressed register port with one 32-bit word per register.
 */
package tpw_pkg;

    // sizes
    localparam int NUM_MATCH = 7;
    localparam int NUM_OUT = 6;
    localparam int ADDR_W = 8;

    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_COUNT = 8'h04;
    localparam logic [7:0] ADDR_PRESCALE = 8'h08;
    localparam logic [7:0] ADDR_PRE_COUNT = 8'h0c;
    localparam logic [7:0] ADDR_MATCH_CTRL = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
    localparam logic [7:0] ADDR_RELEASE = 8'h1c;
    localparam logic [7:0] ADDR_PWM_CFG = 8'h20;
    localparam logic [7:0] ADDR_MATCH_BASE = 8'h40;

    // control register bits
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_RST_BIT = 1;
    localparam int CTRL_PWM_BIT = 3;

    // match control: three bits per match register
    localparam int MCR_STRIDE = 3;
    localparam int MCR_INT_OFS = 0;
    localparam int MCR_RST_OFS = 1;
    localparam int MCR_STOP_OFS = 2;
    localparam int MCR_W = 21;

    // output config: bit n selects double edge for output n (outputs 2 to 6 only), bit 8+n enables output n
    localparam int CFG_W = 15;
    localparam int CFG_OE_OFS = 8;
    localparam logic [14:0] CFG_WMASK = 15'h7e7c;

    // values after reset
    localparam logic [31:0] RST_WORD = 32'h0;
    localparam logic [6:0] RST_FLAGS = 7'h0;
    localparam logic [20:0] RST_MCR = 21'h0;
    localparam logic [14:0] RST_CFG = 15'h0;

endpackage : tpw_pkg

// [tpw_prescale.sv]
/*
 * prescaler: counts enabled clocks and gives a one-cycle tick each time
 * the count reaches its limit, then starts again from zero.
 * assumes the limit comes from a register on the same clock.
 */
module tpw_prescale #(
    parameter int WIDTH = 32
) (
    // clock and reset
    input logic clk,
    input logic sys_rst,
    input logic ce,
    // control
    input logic run,
    input logic clear,
    input logic [WIDTH-1:0] limit,
    // result
    output logic tick,
    output logic [WIDTH-1:0] count
);

    logic [WIDTH-1:0] cnt_q, cnt_d;

    // tick on the last count of each prescale period
    assign tick = run && !clear && (cnt_q == limit);
    assign count = cnt_q;

    // next count
    always_comb
    begin
        cnt_d = cnt_q;
        if (clear)
            cnt_d = '0;
        else if (tick)
            cnt_d = '0;
        else if (run)
            cnt_d = cnt_q + WIDTH'(1);
    end

    // count register, frozen while ce is low
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            cnt_q <= '0;
        else if (ce)
            cnt_q <= cnt_d;
    end

    property p_wrap;
        @(posedge clk) disable iff (sys_rst)
        (ce && run && !clear && cnt_q == limit) |=> (cnt_q == '0);
    endproperty
    a_wrap: assert property (p_wrap) else $error("prescaler did not wrap at limit");

    property p_step;
        @(posedge clk) disable iff (sys_rst)
        (ce && run && !clear && cnt_q != limit) |=> (cnt_q == $past(cnt_q) + WIDTH'(1));
    endproperty
    a_step: assert property (p_step) else $error("prescaler did not advance");

endmodule // tpw_prescale

// [tpw_unit.sv]
/*
 * timer based pulse width unit: 32-bit counter behind a 32-bit prescaler,
 * seven match registers with shadow copies, six modulated outputs,
 * register port and a level interrupt.
 * assumes a synchronous register master on clk and loads on the outputs.
 */
// Contract
// - counter advances from clock and is compared against seven match registers
// - 32-bit counter behind a 32-bit programmable prescaler
// - cycle-period match resets the count, setting the common rate
// - single-edge outputs rise at each cycle-period match
// - each single-edge output falls at its own match
// - single-edge output with zero edge setting stays low all cycle
// - double-edge output uses two matches for rise and fall
// - rise before fall gives positive pulse, else negative
// - either double edge may sit anywhere in the cycle
// - seven matches serve six single, three double, or a mix
// - each match may continue, stop or reset, optionally interrupting
// - period and width are whole counts, one shared rate
// - new match values apply only after release, glitch free
// - with modulation off the block is a plain timer
module tpw_unit #(
    parameter int WIDTH = 32
) (
    // clock and reset
    input logic clk,
    input logic sys_rst,
    input logic ce,
    // register port
    input logic [7:0] addr,
    input logic [31:0] wdata,
    input logic wr,
    input logic rd,
    output logic [31:0] rdata,
    // interrupt
    output logic irq,
    // modulated outputs
    output logic [6:1] pwm_out
);

    // decode of match register addresses, used for write and read
    function automatic logic [6:0] match_sel(input logic [7:0] a);
        logic [6:0] s;
        s = '0;
        for (int i = 0; i < tpw_pkg::NUM_MATCH; i++)
        begin
            if (a == tpw_pkg::ADDR_MATCH_BASE + 8'(4 * i))
                s[i] = 1'b1;
        end
        return s;
    endfunction

    // state
    logic [WIDTH-1:0] tc_q, tc_d;
    logic [WIDTH-1:0] pr_q, pr_d;
    logic en_q, en_d;
    logic crst_q, crst_d;
    logic pwm_mode_q, pwm_mode_d;
    logic [20:0] mcr_q, mcr_d;
    logic [WIDTH-1:0] mr_sh_q [7];
    logic [WIDTH-1:0] mr_sh_d [7];
    logic [WIDTH-1:0] mr_act_q [7];
    logic [WIDTH-1:0] mr_act_d [7];
    logic [6:0] rel_q, rel_d;
    logic [6:0] sts_q, sts_d;
    logic [6:0] msk_q, msk_d;
    logic [14:0] cfg_q, cfg_d;
    logic [6:1] pwm_q, pwm_d;
    logic [31:0] rdata_q, rdata_d;
    logic irq_q, irq_d;

    // combinational helpers
    logic tick;
    logic [WIDTH-1:0] pc;
    logic [6:0] hit, m_int, m_rst, m_stp, wsel;
    logic rst_hit, stp_hit, boundary;
    logic rise_any1; // cycle boundary as seen by the fall check

    // prescaler, held at zero while the counter is in reset
    tpw_prescale #(
        .WIDTH(WIDTH)
    ) u_prescale (
        .clk(clk),
        .sys_rst(sys_rst),
        .ce(ce),
        .run(en_q),
        .clear(crst_q),
        .limit(pr_q),
        .tick(tick),
        .count(pc)
    );

    // match compare and per-match actions
    always_comb
    begin
        for (int i = 0; i < tpw_pkg::NUM_MATCH; i++)
        begin
            hit[i] = tick && (tc_q == mr_act_q[i]);
            m_int[i] = mcr_q[tpw_pkg::MCR_STRIDE * i + tpw_pkg::MCR_INT_OFS];
            m_rst[i] = mcr_q[tpw_pkg::MCR_STRIDE * i + tpw_pkg::MCR_RST_OFS];
            m_stp[i] = mcr_q[tpw_pkg::MCR_STRIDE * i + tpw_pkg::MCR_STOP_OFS];
        end
        boundary = pwm_mode_q && hit[0]; // cycle edge in modulation mode
        rst_hit = (|(hit & m_rst)) || boundary;
        stp_hit = |(hit & m_stp);
        wsel = wr ? match_sel(addr) : 7'h0;
    end

    // counter and control next values
    always_comb
    begin
        tc_d = tc_q;
        pr_d = pr_q;
        en_d = en_q;
        crst_d = crst_q;
        pwm_mode_d = pwm_mode_q;
        mcr_d = mcr_q;
        msk_d = msk_q;
        cfg_d = cfg_q;
        if (crst_q)
            tc_d = '0;
        else if (tick)
            tc_d = rst_hit ? '0 : tc_q + WIDTH'(1);
        if (wr)
        begin
            case (addr)
                tpw_pkg::ADDR_CTRL:
                begin
                    en_d = wdata[tpw_pkg::CTRL_EN_BIT];
                    crst_d = wdata[tpw_pkg::CTRL_RST_BIT];
                    pwm_mode_d = wdata[tpw_pkg::CTRL_PWM_BIT];
                end
                tpw_pkg::ADDR_COUNT: tc_d = wdata[WIDTH-1:0];
                tpw_pkg::ADDR_PRESCALE: pr_d = wdata[WIDTH-1:0];
                tpw_pkg::ADDR_MATCH_CTRL: mcr_d = wdata[20:0];
                tpw_pkg::ADDR_IRQ_MASK: msk_d = wdata[6:0];
                tpw_pkg::ADDR_PWM_CFG: cfg_d = wdata[14:0] & tpw_pkg::CFG_WMASK;
                default: ;
            endcase
        end
        // a stop match wins over a software enable in the same cycle
        if (stp_hit)
            en_d = 1'b0;
    end

    // counter and control registers
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tc_q <= tpw_pkg::RST_WORD;
            pr_q <= tpw_pkg::RST_WORD;
            en_q <= 1'b0;
            crst_q <= 1'b0;
            pwm_mode_q <= 1'b0;
            mcr_q <= tpw_pkg::RST_MCR;
            msk_q <= tpw_pkg::RST_FLAGS;
            cfg_q <= tpw_pkg::RST_CFG;
        end
        else if (ce)
        begin
            tc_q <= tc_d;
            pr_q <= pr_d;
            en_q <= en_d;
            crst_q <= crst_d;
            pwm_mode_q <= pwm_mode_d;
            mcr_q <= mcr_d;
            msk_q <= msk_d;
            cfg_q <= cfg_d;
        end
    end

    // shadow, release and active match values
    always_comb
    begin
        rel_d = rel_q;
        for (int i = 0; i < tpw_pkg::NUM_MATCH; i++)
        begin
            mr_sh_d[i] = mr_sh_q[i];
            mr_act_d[i] = mr_act_q[i];
            // released values move only at the cycle boundary
            if (boundary && rel_q[i])
                mr_act_d[i] = mr_sh_q[i];
            if (wsel[i])
            begin
                mr_sh_d[i] = wdata[WIDTH-1:0];
                if (!pwm_mode_q)
                    mr_act_d[i] = wdata[WIDTH-1:0];
            end
        end
        if (boundary)
            rel_d = 7'h0;
        // a release written at the boundary waits for the next one
        if (wr && addr == tpw_pkg::ADDR_RELEASE)
            rel_d = rel_d | wdata[6:0];
    end

    // match registers
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rel_q <= tpw_pkg::RST_FLAGS;
            for (int i = 0; i < tpw_pkg::NUM_MATCH; i++)
            begin
                mr_sh_q[i] <= tpw_pkg::RST_WORD;
                mr_act_q[i] <= tpw_pkg::RST_WORD;
            end
        end
        else if (ce)
        begin
            rel_q <= rel_d;
            for (int i = 0; i < tpw_pkg::NUM_MATCH; i++)
            begin
                mr_sh_q[i] <= mr_sh_d[i];
                mr_act_q[i] <= mr_act_d[i];
            end
        end
    end

    // output waveforms: single edge uses match 0 and match n,
    // double edge uses match n-1 to rise and match n to fall
    always_comb
    begin
        for (int n = 1; n <= tpw_pkg::NUM_OUT; n++)
        begin
            logic dbl, rise, fall;
            dbl = (n >= 2) && cfg_q[n];
            rise = dbl ? hit[n - 1] : hit[0];
            fall = hit[n];
            pwm_d[n] = pwm_q[n];
            // fall wins a tie; rise before fall or after it sets polarity
            if (fall || (!dbl && rise && mr_act_d[n] == '0))
                pwm_d[n] = 1'b0;
            else if (rise)
                pwm_d[n] = 1'b1;
            if (!pwm_mode_q || !cfg_q[tpw_pkg::CFG_OE_OFS + n])
                pwm_d[n] = 1'b0;
        end
    end

    // status, interrupt and read data next values
    always_comb
    begin
        sts_d = sts_q;
        if (wr && addr == tpw_pkg::ADDR_IRQ_STATUS)
            sts_d = sts_q & ~wdata[6:0];
        sts_d = sts_d | (hit & m_int);
        irq_d = |(sts_d & msk_d);
        rdata_d = 32'h0;
        if (rd)
        begin
            case (addr)
                tpw_pkg::ADDR_CTRL:
                begin
                    rdata_d[tpw_pkg::CTRL_EN_BIT] = en_q;
                    rdata_d[tpw_pkg::CTRL_RST_BIT] = crst_q;
                    rdata_d[tpw_pkg::CTRL_PWM_BIT] = pwm_mode_q;
                end
                tpw_pkg::ADDR_COUNT: rdata_d[WIDTH-1:0] = tc_q;
                tpw_pkg::ADDR_PRESCALE: rdata_d[WIDTH-1:0] = pr_q;
                tpw_pkg::ADDR_PRE_COUNT: rdata_d[WIDTH-1:0] = pc;
                tpw_pkg::ADDR_MATCH_CTRL: rdata_d[20:0] = mcr_q;
                tpw_pkg::ADDR_IRQ_STATUS: rdata_d[6:0] = sts_q;
                tpw_pkg::ADDR_IRQ_MASK: rdata_d[6:0] = msk_q;
                tpw_pkg::ADDR_RELEASE: rdata_d[6:0] = rel_q;
                tpw_pkg::ADDR_PWM_CFG: rdata_d[14:0] = cfg_q;
                default:
                begin
                    for (int i = 0; i < tpw_pkg::NUM_MATCH; i++)
                    begin
                        if (match_sel(addr) == 7'(1 << i))
                            rdata_d[WIDTH-1:0] = mr_sh_q[i];
                    end
                end
            endcase
        end
    end

    // status, outputs and read data registers
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sts_q <= tpw_pkg::RST_FLAGS;
            irq_q <= 1'b0;
            pwm_q <= 6'h0;
            rdata_q <= tpw_pkg::RST_WORD;
        end
        else if (ce)
        begin
            sts_q <= sts_d;
            irq_q <= irq_d;
            pwm_q <= pwm_d;
            rdata_q <= rdata_d;
        end
    end

    assign rdata = rdata_q;
    assign irq = irq_q;
    assign pwm_out = pwm_q;

    property p_count_step;
        @(posedge clk) disable iff (sys_rst)
        (ce && tick && !rst_hit && !wr) |=> (tc_q == $past(tc_q) + WIDTH'(1));
    endproperty
    a_count_step: assert property (p_count_step) else $error("counter did not advance on tick");

    property p_period_reset;
        @(posedge clk) disable iff (sys_rst)
        (ce && boundary && !wr) |=> (tc_q == '0);
    endproperty
    a_period_reset: assert property (p_period_reset) else $error("count not reset at period match");

    property p_single_rise;
        @(posedge clk) disable iff (sys_rst)
        (ce && boundary && cfg_q[tpw_pkg::CFG_OE_OFS + 1] && mr_act_d[1] != '0 && !hit[1])
            |=> pwm_q[1];
    endproperty
    a_single_rise: assert property (p_single_rise) else $error("single edge output did not rise");

    property p_single_fall;
        @(posedge clk) disable iff (sys_rst)
        (ce && hit[1]) |=> !pwm_q[1] ##1 (!pwm_q[1] || $past(ce && rise_any1));
    endproperty
    assign rise_any1 = boundary;
    a_single_fall: assert property (p_single_fall) else $error("single edge output did not fall");

    property p_const_low;
        @(posedge clk) disable iff (sys_rst)
        (ce && boundary) ##1 (mr_act_q[6] == '0 && !cfg_q[6]) |-> !pwm_q[6];
    endproperty
    a_const_low: assert property (p_const_low) else $error("zero edge output rose");

    property p_double_pos;
        @(posedge clk) disable iff (sys_rst)
        (ce && pwm_mode_q && cfg_q[2] && cfg_q[tpw_pkg::CFG_OE_OFS + 2] && hit[1] && !hit[2])
            |=> pwm_q[2];
    endproperty
    a_double_pos: assert property (p_double_pos) else $error("double edge output did not rise");

    property p_stop;
        @(posedge clk) disable iff (sys_rst)
        (ce && stp_hit) |=> !en_q ##1 (!en_q || $past(wr));
    endproperty
    a_stop: assert property (p_stop) else $error("stop match did not halt counter");

    property p_transfer;
        @(posedge clk) disable iff (sys_rst)
        (ce && boundary && rel_q[2] && !wsel[2]) |=> (mr_act_q[2] == $past(mr_sh_q[2]));
    endproperty
    a_transfer: assert property (p_transfer) else $error("released value not applied at boundary");

    property p_no_mid_cycle;
        @(posedge clk) disable iff (sys_rst)
        (pwm_mode_q && !(ce && boundary)) |=> $stable(mr_act_q[2]);
    endproperty
    a_no_mid_cycle: assert property (p_no_mid_cycle) else $error("active match changed mid cycle");

    property p_timer_off;
        @(posedge clk) disable iff (sys_rst)
        (!pwm_mode_q && ce) |=> (pwm_q == 6'h0);
    endproperty
    a_timer_off: assert property (p_timer_off) else $error("output active in timer mode");

endmodule // tpw_unit

// [tpw_load.sv]
/*
 * load model on the modulated pins: tallies high cycles and rising edges
 * of every output over a window that the bench opens with clr.
 * assumes the pins are registered on clk and clr is driven on clk.
 */
module tpw_load (
    // clock
    input wire logic clk,
    // window control
    input wire logic clr,
    // observed pins
    input wire logic [6:1] pins,
    // measurements
    output logic [6:1][7:0] hi_cnt,
    output logic [6:1][7:0] rise_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [6:1] prev;

    // one shared window for all pins, so a common rate shows as equal tallies
    always @(posedge clk)
    begin
        prev <= pins;
        for (int n = 1; n <= 6; n++)
        begin
            hi_cnt[n] <= clr ? 8'h00 : hi_cnt[n] + 8'(pins[n]);
            rise_cnt[n] <= clr ? 8'h00 : rise_cnt[n] + 8'(pins[n] & ~prev[n]);
        end
    end
endmodule // tpw_load

// [timer_based_pwm_unit_tb_top.sv]
/*
 * self-checking bench for the pulse width unit: register port, timer stop
 * and interrupt, single and double edge outputs, release of new matches.
 * assumes tpw_unit and tpw_load are compiled before it.
 */
module timer_based_pwm_unit_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, sys_rst, ce, wr, rd, clr, irq;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, v, w;
    logic [6:1] pwm_out;
    logic [6:1][7:0] hi_cnt, rise_cnt;
    logic [14:0] cfg;
    int num_errors, checks, seed, per, lim, nv;
    int m [0:6];

    tpw_unit #(.WIDTH(32)) dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .pwm_out(pwm_out));
    tpw_load load (.clk(clk), .clr(clr), .pins(pwm_out), .hi_cnt(hi_cnt), .rise_cnt(rise_cnt));

    // 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // verdict and end of run
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // word compare
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // bus cycles: one strobe cycle, read data in the following cycle only
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        rd_reg(a, v);
        chk(what, exp, v);
    endtask

    // bounded poll until the given bits read back clear
    task automatic wait_clear(input logic [7:0] a, input logic [31:0] bits);
        int i;
        for (i = 0; i < 200; i++)
        begin
            rd_reg(a, v);
            if ((v & bits) === 32'h0)
                break;
        end
        if (i == 200)
        begin
            num_errors++;
            $display("Error poll %h expected 0 seen %h", a, v & bits);
            report_and_stop();
        end
    endtask

    function automatic int rnd(input int n);
        rnd = $unsigned($random(seed)) % n;
    endfunction

    // expected high counts per period for output n
    function automatic int exp_high(input int n);
        int r, f;
        if (!cfg[n])
            return (m[n] == 0) ? 0 : m[n] + 1;
        r = m[n-1];
        f = m[n];
        if (r == f)
            return 0;
        return (r < f) ? f - r : per - (r - f);
    endfunction

    // one period window on the loads, all six outputs compared
    task automatic measure;
        int eh, span;
        span = per * (lim + 1);
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (span) @(posedge clk);
        #1;
        for (int n = 1; n <= 6; n++)
        begin
            eh = exp_high(n) * (lim + 1);
            chk($sformatf("high time out%0d", n), 32'(eh), 32'(hi_cnt[n]));
            chk($sformatf("edges out%0d", n), (eh > 0 && eh < span) ? 32'h1 : 32'h0, 32'(rise_cnt[n]));
        end
    endtask

    // load matches while timer mode writes active, then run in modulation mode
    task automatic program_pwm;
        wr_reg(tpw_pkg::ADDR_CTRL, 32'h2);
        wr_reg(tpw_pkg::ADDR_PRESCALE, 32'(lim));
        wr_reg(tpw_pkg::ADDR_MATCH_CTRL, 32'h2);
        for (int i = 0; i <= 6; i++)
            wr_reg(tpw_pkg::ADDR_MATCH_BASE + 8'(4 * i), 32'(m[i]));
        wr_reg(tpw_pkg::ADDR_PWM_CFG, {17'h0, cfg});
        wr_reg(tpw_pkg::ADDR_CTRL, 32'h9);
        repeat (2 * per * (lim + 1)) @(posedge clk);
        measure();
    endtask

    // hang guard
    initial
    begin
        repeat (100000) @(posedge clk);
        num_errors++;
        $display("Error run length expected end seen hang");
        report_and_stop();
    end

    // main sequence
    initial
    begin
        seed = 87;
        num_errors = 0;
        checks = 0;
        sys_rst = 1'b1;
        ce = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        clr = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        chk("pwm after reset", 32'h0, {26'h0, pwm_out});
        rd_chk("ctrl", tpw_pkg::ADDR_CTRL, tpw_pkg::RST_WORD);
        rd_chk("match ctrl", tpw_pkg::ADDR_MATCH_CTRL, {11'h0, tpw_pkg::RST_MCR});
        rd_chk("cfg", tpw_pkg::ADDR_PWM_CFG, {17'h0, tpw_pkg::RST_CFG});
        wr_reg(8'h30, 32'hffffffff);
        rd_chk("unmapped", 8'h30, 32'h0);
        for (int i = 1; i <= 6; i++)
        begin
            w = $random(seed) | 32'h100;
            wr_reg(tpw_pkg::ADDR_MATCH_BASE + 8'(4 * i), w);
            rd_chk("match shadow", tpw_pkg::ADDR_MATCH_BASE + 8'(4 * i), w);
        end
        wr_reg(tpw_pkg::ADDR_PWM_CFG, 32'hffffffff);
        rd_chk("cfg mask", tpw_pkg::ADDR_PWM_CFG, {17'h0, tpw_pkg::CFG_WMASK});
        wr_reg(tpw_pkg::ADDR_MATCH_BASE, 32'h11);
        @(posedge clk);
        ce <= 1'b0;
        wr_reg(tpw_pkg::ADDR_MATCH_BASE, 32'h22);
        @(posedge clk);
        ce <= 1'b1;
        rd_chk("write with ce low", tpw_pkg::ADDR_MATCH_BASE, 32'h11);
        $display("test registers done");
        // stop on match with interrupt, timer mode
        wr_reg(tpw_pkg::ADDR_CTRL, 32'h2);
        wr_reg(tpw_pkg::ADDR_PRESCALE, 32'h1);
        wr_reg(tpw_pkg::ADDR_MATCH_CTRL, 32'h140);
        wr_reg(tpw_pkg::ADDR_MATCH_BASE + 8'h08, 32'h4);
        wr_reg(tpw_pkg::ADDR_CTRL, 32'h1);
        wait_clear(tpw_pkg::ADDR_CTRL, 32'h1);
        rd_chk("stop status", tpw_pkg::ADDR_IRQ_STATUS, 32'h4);
        rd_chk("stop count", tpw_pkg::ADDR_COUNT, 32'h5);
        rd_chk("prescale count", tpw_pkg::ADDR_PRE_COUNT, 32'h0);
        chk("irq masked", 32'h0, {31'h0, irq});
        chk("pwm timer mode", 32'h0, {26'h0, pwm_out});
        wr_reg(tpw_pkg::ADDR_IRQ_MASK, 32'h4);
        repeat (2) @(posedge clk);
        #1;
        chk("irq unmasked", 32'h1, {31'h0, irq});
        wr_reg(tpw_pkg::ADDR_IRQ_STATUS, 32'h4);
        repeat (2) @(posedge clk);
        #1;
        chk("irq cleared", 32'h0, {31'h0, irq});
        $display("test stop and interrupt done");
        // six single edge outputs, one at zero edge setting
        per = 6 + rnd(7);
        lim = rnd(3);
        m[0] = per - 1;
        for (int i = 1; i <= 5; i++)
            m[i] = 1 + rnd(per - 2);
        m[6] = 0;
        cfg = 15'h7e00;
        program_pwm();
        $display("test single edge done");
        // three double edge outputs mixed with singles, both polarities
        m[1] = 1;
        m[2] = per - 2;
        m[3] = per - 2;
        m[4] = 1;
        cfg = 15'h7e54;
        program_pwm();
        $display("test double edge done");
        // new value held in shadow until released, then applied at boundary
        nv = per - 3;
        wr_reg(tpw_pkg::ADDR_MATCH_BASE + 8'h08, 32'(nv));
        measure();
        rd_chk("release idle", tpw_pkg::ADDR_RELEASE, 32'h0);
        wr_reg(tpw_pkg::ADDR_RELEASE, 32'h4);
        wait_clear(tpw_pkg::ADDR_RELEASE, 32'h4);
        m[2] = nv;
        measure();
        $display("test release done");
        report_and_stop();
    end
endmodule // timer_based_pwm_unit_tb_top
